// file: core/nip_defines.svh
// offsets, field positions, reset values and wait counts of the nibble host port
`ifndef NIP_DEFINES_SVH
`define NIP_DEFINES_SVH
`define NIP_CLK_MHZ 125
`define NIP_POR_MS 2
`define NIP_GAP1_MS 2
`define NIP_GAP2_US 40
`define NIP_EXEC_US 40
`define NIP_CLEAR_US 2000
`define NIP_POR_CYC (`NIP_POR_MS * 1000 * `NIP_CLK_MHZ)
`define NIP_GAP1_CYC (`NIP_GAP1_MS * 1000 * `NIP_CLK_MHZ)
`define NIP_GAP2_CYC (`NIP_GAP2_US * `NIP_CLK_MHZ)
`define NIP_EXEC_CYC (`NIP_EXEC_US * `NIP_CLK_MHZ)
`define NIP_CLEAR_CYC (`NIP_CLEAR_US * `NIP_CLK_MHZ)
`define NIP_TIMER_W 18
`define NIP_OFS_CTRL 12'h000
`define NIP_OFS_STATUS 12'h004
`define NIP_OFS_ERR 12'h008
`define NIP_OFS_INSTR 12'h00C
`define NIP_CTRL_EN_BIT 0
`define NIP_CTRL_REINIT_BIT 1
`define NIP_CTRL_EN_RESET 1'b1
`define NIP_ERR_EARLY_BIT 0
`define NIP_ERR_ORDER_BIT 1
`define NIP_FS_MASK 8'hE0
`define NIP_FS_CODE 8'h20
`define NIP_FS_DL_BIT 4
`define NIP_FS_N_BIT 3
`define NIP_FS_M_BIT 2
`define NIP_DCTL_MASK 8'hF8
`define NIP_DCTL_CODE 8'h08
`define NIP_DCTL_D_BIT 2
`define NIP_DCTL_C_BIT 1
`define NIP_DCTL_B_BIT 0
`define NIP_CLR_CODE 8'h01
`define NIP_ENTRY_MASK 8'hFC
`define NIP_ENTRY_CODE 8'h04
`define NIP_ENTRY_ID_BIT 1
`define NIP_ENTRY_S_BIT 0
`define NIP_ENTRY_ID_RESET 1'b1
`endif

// file: core/nip_pkg.sv
// types shared by the nibble host port modules
package nip_pkg;
    typedef enum logic [3:0] {
        ST_POR = 4'h0, ST_FS1 = 4'h1, ST_FS2 = 4'h3, ST_FS3 = 4'h2, ST_WIDTH4 = 4'h6,
        ST_FS4 = 4'h7, ST_DOFF = 4'h5, ST_CLR = 4'h4, ST_DONE = 4'hC
    } nip_step_e;
    typedef struct packed {
        logic initDone;
        logic shift;
        logic incr;
        logic dispOn;
        logic voltGen;
        logic lineCount;
        nip_step_e step;
        logic busy;
        logic fourBit;
    } nip_status_s;
endpackage

// file: core/nip_ctl_if.sv
// control and status carried between the port core and its register file
`timescale 1ns/1ps
`default_nettype none
interface nip_ctl_if;
    import nip_pkg::*;
    logic portEnable;
    logic reinit;
    nip_status_s status;
    logic [1:0] errSet;
    logic [7:0] lastInstr;
    modport regs (output portEnable, output reinit, input status, input errSet, input lastInstr);
    modport core (input portEnable, input reinit, output status, output errSet, output lastInstr);
endinterface
`default_nettype wire

// file: core/nip_busy_timer.sv
// down counter that holds the execution or wait time of the last instruction
`timescale 1ns/1ps
`default_nettype none
module nip_busy_timer #(
    parameter int unsigned TW = 18,
    parameter int unsigned RESET_LOAD = 250000
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // load and state
    input wire logic start,
    input wire logic [TW-1:0] loadVal,
    output logic busy
);
    logic [TW-1:0] count;

    if (RESET_LOAD >= (2 ** TW)) begin : g_bad_load
        $error("reset load does not fit the timer");
    end

    // a new start restarts the wait, so a premature write replaces what is left of busy with its own load
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            count <= TW'(RESET_LOAD);
        end else if (start) begin
            count <= loadVal;
        end else if (count != '0) begin
            count <= count - TW'(1);
        end
    end

    assign busy = (count != '0);
endmodule
`default_nettype wire

// file: core/nip_apb_regs.sv
// apb register file of the nibble host port
`timescale 1ns/1ps
`default_nettype none
`include "nip_defines.svh"
module nip_apb_regs (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core side
    nip_ctl_if.regs ctl
);
    import nip_pkg::*;
    logic [1:0] err;
    logic wrDone;
    logic mapped;
    logic [31:0] rdMux;

    assign wrDone = psel & penable & pready & pwrite;
    assign mapped = (paddr == `NIP_OFS_CTRL) || (paddr == `NIP_OFS_STATUS) ||
                    (paddr == `NIP_OFS_ERR) || (paddr == `NIP_OFS_INSTR);

    always_comb begin
        rdMux = 32'h0000_0000;
        unique case (paddr)
            `NIP_OFS_CTRL: rdMux[`NIP_CTRL_EN_BIT] = ctl.portEnable;
            `NIP_OFS_STATUS: rdMux[$bits(nip_status_s)-1:0] = ctl.status;
            `NIP_OFS_ERR: rdMux[1:0] = err;
            `NIP_OFS_INSTR: rdMux[7:0] = ctl.lastInstr;
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // no wait state: pready is high in the first access cycle and falls after it
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            if (psel && !penable) begin
                prdata <= pwrite ? 32'h0000_0000 : rdMux;
                pslverr <= ~mapped;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctl.portEnable <= `NIP_CTRL_EN_RESET;
            ctl.reinit <= 1'b0;
        end else begin
            ctl.reinit <= wrDone && (paddr == `NIP_OFS_CTRL) && pwdata[`NIP_CTRL_REINIT_BIT];
            if (wrDone && (paddr == `NIP_OFS_CTRL)) begin
                ctl.portEnable <= pwdata[`NIP_CTRL_EN_BIT];
            end
        end
    end

    // write one clears; a new error in the same cycle wins over the clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            err <= 2'h0;
        end else begin
            err <= (err & ~((wrDone && (paddr == `NIP_OFS_ERR)) ? pwdata[1:0] : 2'h0)) | ctl.errSet;
        end
    end
endmodule
`default_nettype wire

// file: core/nip_port_top.sv
// nibble-wide host port of the display controller with its power-up sequence tracker
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - three blind 8-bit function sets, timed gaps
// - fourth write 0010 switches port to 4-bit
// - 4-bit instructions come as two nibbles, high first
// - second function nibble carries line count, voltage
// - busy readable after switch, else host waits
`include "nip_defines.svh"
module nip_port_top #(
    parameter int unsigned TW = `NIP_TIMER_W,
    parameter int unsigned POR_CYC = `NIP_POR_CYC,
    parameter int unsigned GAP1_CYC = `NIP_GAP1_CYC,
    parameter int unsigned GAP2_CYC = `NIP_GAP2_CYC,
    parameter int unsigned EXEC_CYC = `NIP_EXEC_CYC,
    parameter int unsigned CLEAR_CYC = `NIP_CLEAR_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // display host port; bit 3 is the top data line, bit 0 the low one
    input wire logic portStrobe,
    input wire logic instrDataSelect,
    input wire logic readNotWrite,
    input wire logic [3:0] upperDataIn,
    output logic [3:0] upperDataOut,
    output logic upperDataEnN
);
    import nip_pkg::*;

    nip_ctl_if ctl ();

    logic strobeLast;
    logic strobeFall;
    logic wrStrobe;
    logic rdStrobe;
    logic nibLow;
    logic [3:0] highNib;
    logic highSel;
    logic instrValid;
    logic [7:0] instrByte;
    logic instrSel;
    logic cmdValid;
    logic dataValid;
    logic isFs;
    logic isDctl;
    logic isClr;
    logic isEntry;
    logic stepOk;
    nip_step_e step;
    nip_step_e next_step;
    logic fourBit;
    logic reportBusy;
    logic lineCount;
    logic voltGen;
    logic dispOn;
    logic cursorOn;
    logic blinkOn;
    logic incr;
    logic shift;
    logic [6:0] addrCount;
    logic timerStart;
    logic [TW-1:0] timerLoad;
    logic timerBusy;
    logic busyFlag;
    logic [7:0] readByte;

    if (POR_CYC >= (2 ** TW) || GAP1_CYC >= (2 ** TW) || CLEAR_CYC >= (2 ** TW) ||
        GAP2_CYC < 2 || EXEC_CYC < 2) begin : g_bad_param
        $error("wait counts do not fit the busy timer");
    end

    nip_apb_regs u_regs (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .ctl(ctl.regs)
    );

    // the power-up wait is loaded at reset so that writes inside it are flagged
    nip_busy_timer #(
        .TW(TW),
        .RESET_LOAD(POR_CYC)
    ) u_timer (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .start(timerStart),
        .loadVal(timerLoad),
        .busy(timerBusy)
    );

    // strobe edge detect; pins are already synchronous to ref_clk
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            strobeLast <= 1'b0;
        end else begin
            strobeLast <= portStrobe;
        end
    end

    assign strobeFall = strobeLast & ~portStrobe;
    assign wrStrobe = strobeFall & ~readNotWrite & ctl.portEnable;
    assign rdStrobe = strobeFall & readNotWrite & ctl.portEnable;

    // reads and writes share one nibble phase, as the host counts them together
    always_ff @(posedge ref_clk) begin
        if (sys_rst || ctl.reinit) begin
            nibLow <= 1'b0;
            highNib <= 4'h0;
            highSel <= 1'b0;
        end else if (fourBit && (wrStrobe || rdStrobe)) begin
            nibLow <= ~nibLow;
            if (wrStrobe && !nibLow) begin
                highNib <= upperDataIn;
                highSel <= instrDataSelect;
            end
        end
    end

    // in 8-bit width the unwired low lines read as zero
    assign instrValid = wrStrobe & (~fourBit | nibLow);
    assign instrByte = fourBit ? {highNib, upperDataIn} : {upperDataIn, 4'h0};
    assign instrSel = fourBit ? highSel : instrDataSelect;
    assign cmdValid = instrValid & ~instrSel;
    assign dataValid = instrValid & instrSel;

    assign isFs = (instrByte & `NIP_FS_MASK) == `NIP_FS_CODE;
    assign isDctl = (instrByte & `NIP_DCTL_MASK) == `NIP_DCTL_CODE;
    assign isClr = instrByte == `NIP_CLR_CODE;
    assign isEntry = (instrByte & `NIP_ENTRY_MASK) == `NIP_ENTRY_CODE;

    always_comb begin
        next_step = step;
        stepOk = 1'b0;
        unique case (step)
            ST_POR: begin
                stepOk = isFs && instrByte[`NIP_FS_DL_BIT];
                next_step = ST_FS1;
            end
            ST_FS1: begin
                stepOk = isFs && instrByte[`NIP_FS_DL_BIT];
                next_step = ST_FS2;
            end
            ST_FS2: begin
                stepOk = isFs && instrByte[`NIP_FS_DL_BIT];
                next_step = ST_FS3;
            end
            ST_FS3: begin
                stepOk = isFs && !instrByte[`NIP_FS_DL_BIT];
                next_step = ST_WIDTH4;
            end
            ST_WIDTH4: begin
                stepOk = isFs && !instrByte[`NIP_FS_DL_BIT];
                next_step = ST_FS4;
            end
            ST_FS4: begin
                stepOk = isDctl && !instrByte[`NIP_DCTL_D_BIT];
                next_step = ST_DOFF;
            end
            ST_DOFF: begin
                stepOk = isClr;
                next_step = ST_CLR;
            end
            ST_CLR: begin
                stepOk = isEntry;
                next_step = ST_DONE;
            end
            ST_DONE: begin
                stepOk = 1'b1;
                next_step = ST_DONE;
            end
            default: begin
                stepOk = 1'b0;
                next_step = ST_POR;
            end
        endcase
        if (!stepOk && step != ST_POR && step != ST_FS1 && step != ST_FS2 && step != ST_FS3 &&
            step != ST_WIDTH4 && step != ST_FS4 && step != ST_DOFF && step != ST_CLR) begin
            next_step = ST_POR;
        end else if (!stepOk) begin
            next_step = step;
        end
    end

    // an out-of-order instruction still executes but leaves the tracker where it is
    always_ff @(posedge ref_clk) begin
        if (sys_rst || ctl.reinit) begin
            step <= ST_POR;
        end else if (cmdValid) begin
            step <= next_step;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || ctl.reinit) begin
            fourBit <= 1'b0;
            reportBusy <= 1'b0;
        end else if (cmdValid && isFs) begin
            fourBit <= ~instrByte[`NIP_FS_DL_BIT];
            if (!fourBit && !instrByte[`NIP_FS_DL_BIT]) begin
                reportBusy <= 1'b1;
            end
        end
    end

    // line count and voltage bits only exist when the low nibble was really sent
    always_ff @(posedge ref_clk) begin
        if (sys_rst || ctl.reinit) begin
            lineCount <= 1'b0;
            voltGen <= 1'b0;
        end else if (cmdValid && isFs && fourBit) begin
            lineCount <= instrByte[`NIP_FS_N_BIT];
            voltGen <= instrByte[`NIP_FS_M_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || ctl.reinit) begin
            dispOn <= 1'b0;
            cursorOn <= 1'b0;
            blinkOn <= 1'b0;
            incr <= `NIP_ENTRY_ID_RESET;
            shift <= 1'b0;
        end else if (cmdValid && isDctl) begin
            dispOn <= instrByte[`NIP_DCTL_D_BIT];
            cursorOn <= instrByte[`NIP_DCTL_C_BIT];
            blinkOn <= instrByte[`NIP_DCTL_B_BIT];
        end else if (cmdValid && isEntry) begin
            incr <= instrByte[`NIP_ENTRY_ID_BIT];
            shift <= instrByte[`NIP_ENTRY_S_BIT];
        end
    end

    // address counter moves with each data write in the entry direction
    always_ff @(posedge ref_clk) begin
        if (sys_rst || ctl.reinit) begin
            addrCount <= 7'h00;
        end else if (cmdValid && isClr) begin
            addrCount <= 7'h00;
        end else if (dataValid) begin
            addrCount <= incr ? addrCount + 7'h01 : addrCount - 7'h01;
        end
    end

    // gaps of the blind writes are enforced by the same timer as execution times
    always_comb begin
        timerStart = instrValid | ctl.reinit;
        if (ctl.reinit) begin
            timerLoad = TW'(POR_CYC);
        end else if (cmdValid && step == ST_POR) begin
            timerLoad = TW'(GAP1_CYC);
        end else if (cmdValid && step == ST_FS1) begin
            timerLoad = TW'(GAP2_CYC);
        end else if (cmdValid && isClr) begin
            timerLoad = TW'(CLEAR_CYC);
        end else begin
            timerLoad = TW'(EXEC_CYC);
        end
    end

    // before the width switch the flag reads idle since the host may not poll yet
    assign busyFlag = timerBusy & reportBusy;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctl.errSet <= 2'h0;
            ctl.lastInstr <= 8'h00;
        end else begin
            ctl.errSet[`NIP_ERR_EARLY_BIT] <= instrValid & timerBusy;
            ctl.errSet[`NIP_ERR_ORDER_BIT] <= cmdValid & ~stepOk;
            if (cmdValid) begin
                ctl.lastInstr <= instrByte;
            end
        end
    end

    always_comb begin
        ctl.status = '0;
        ctl.status.initDone = (step == ST_DONE);
        ctl.status.shift = shift;
        ctl.status.incr = incr;
        ctl.status.dispOn = dispOn;
        ctl.status.voltGen = voltGen;
        ctl.status.lineCount = lineCount;
        ctl.status.step = step;
        ctl.status.busy = timerBusy;
        ctl.status.fourBit = fourBit;
    end

    // display memory sits outside this block, so data reads return zero
    assign readByte = instrDataSelect ? 8'h00 : {busyFlag, addrCount};

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            upperDataOut <= 4'h0;
            upperDataEnN <= 1'b1;
        end else begin
            upperDataEnN <= ~(portStrobe & readNotWrite & ctl.portEnable);
            upperDataOut <= (fourBit && nibLow) ? readByte[3:0] : readByte[7:4];
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_high_half;
        fourBit && wrStrobe && !nibLow && !ctl.reinit;
    endsequence

    sequence s_width_write;
        step == ST_FS3 && cmdValid && isFs && !instrByte[`NIP_FS_DL_BIT] && !ctl.reinit;
    endsequence

    chk_pair_order: assert property (
        s_high_half |=> nibLow && highNib == $past(upperDataIn)
    ) else $error("high nibble not held for pairing");

    chk_width_switch: assert property (
        s_width_write |=> fourBit && reportBusy && step == ST_WIDTH4 && !nibLow
    ) else $error("port did not switch to 4-bit width");

    chk_blind_quiet: assert property (
        !reportBusy && !(cmdValid && isFs && !instrByte[`NIP_FS_DL_BIT]) |=> !busyFlag
    ) else $error("busy reported before width switch");

    chk_blind_gap: assert property (
        step == ST_POR && cmdValid && stepOk && !ctl.reinit |=> (timerBusy && step == ST_FS1) [*8]
    ) else $error("first blind write gap not held");

    chk_busy_report: assert property (
        reportBusy && instrValid && !ctl.reinit |=> busyFlag [*2]
    ) else $error("busy not reported after instruction");

    chk_fs_fields: assert property (
        step == ST_WIDTH4 && cmdValid && isFs && !ctl.reinit
        |=> lineCount == $past(upperDataIn[3]) && voltGen == $past(upperDataIn[2]) && step == ST_FS4
    ) else $error("line count or voltage bit not taken");

    chk_init_done: assert property (
        step == ST_CLR && cmdValid && isEntry && !ctl.reinit
        |=> ctl.status.initDone && incr == $past(upperDataIn[1]) && shift == $past(upperDataIn[0])
    ) else $error("entry mode did not end initialisation");

    chk_clear_addr: assert property (
        cmdValid && isClr && !ctl.reinit |=> addrCount == 7'h00 ##1 timerBusy [*2]
    ) else $error("clear did not reset address counter");

    chk_read_drive: assert property (
        portStrobe && readNotWrite && !instrDataSelect && ctl.portEnable && !(fourBit && nibLow)
        |=> !upperDataEnN && upperDataOut[3] == $past(busyFlag)
    ) else $error("busy flag not driven on status read");
endmodule
`default_nettype wire

// file: verification/nip_host_model.sv
// host microcontroller model driving the nibble host port
`timescale 1ns/1ps
`default_nettype none
module nip_host_model (
    // clock
    input wire logic ref_clk,
    // host port
    output logic portStrobe,
    output logic instrDataSelect,
    output logic readNotWrite,
    output logic [3:0] upperDataIn,
    input wire logic [3:0] upperDataOut,
    input wire logic upperDataEnN
);
    // register select applied by the next write or read
    logic rsSel = 1'b0;
    initial begin
        portStrobe = 1'b0;
        instrDataSelect = 1'b0;
        readNotWrite = 1'b0;
        upperDataIn = 4'h5;
    end
    // nibble held through the falling strobe, then released to its inverse so stale data never matches
    task automatic wr_nib(input logic [3:0] n);
        instrDataSelect <= rsSel;
        readNotWrite <= 1'b0;
        upperDataIn <= n;
        portStrobe <= 1'b1;
        @(posedge ref_clk);
        portStrobe <= 1'b0;
        @(posedge ref_clk);
        upperDataIn <= ~n;
        @(posedge ref_clk);
    endtask
    task automatic wr_pair(input logic [3:0] hi, input logic [3:0] lo);
        wr_nib(hi);
        wr_nib(lo);
    endtask
    task automatic rd_nib(output logic [3:0] d, output logic enN);
        instrDataSelect <= rsSel;
        readNotWrite <= 1'b1;
        portStrobe <= 1'b1;
        upperDataIn <= ~upperDataIn;
        repeat (2) @(posedge ref_clk);
        d = upperDataOut;
        enN = upperDataEnN;
        portStrobe <= 1'b0;
        @(posedge ref_clk);
        readNotWrite <= 1'b0;
        @(posedge ref_clk);
    endtask
    // blind waits: the host does not poll before the width switch
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// file: verification/nibble_port_init_sequence_tb.sv
// self-checking bench of the nibble host port power-up sequence
`timescale 1ns/1ps
`default_nettype none
`include "nip_defines.svh"
module nibble_port_init_sequence_tb;
    import nip_pkg::*;
    // shortened wait counts keep the run small
    localparam int POR = 40;
    localparam int GAP1 = 30;
    localparam int GAP2 = 10;
    localparam int EXEC = 10;
    localparam int CLR = 20;
    localparam int LIMIT = 20000;
    logic ref_clk = 1'b0;
    logic sys_rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic portStrobe;
    logic instrDataSelect;
    logic readNotWrite;
    logic [3:0] upperDataIn;
    logic [3:0] upperDataOut;
    logic upperDataEnN;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    nip_status_s st;
    logic [31:0] rd;
    logic err;
    logic [3:0] nib;
    logic enN;

    nip_port_top #(.POR_CYC(POR), .GAP1_CYC(GAP1), .GAP2_CYC(GAP2), .EXEC_CYC(EXEC), .CLEAR_CYC(CLR))
        nip_port_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .portStrobe(portStrobe), .instrDataSelect(instrDataSelect),
        .readNotWrite(readNotWrite), .upperDataIn(upperDataIn), .upperDataOut(upperDataOut),
        .upperDataEnN(upperDataEnN));
    nip_host_model nip_host_model_inst (.ref_clk(ref_clk), .portStrobe(portStrobe),
        .instrDataSelect(instrDataSelect), .readNotWrite(readNotWrite), .upperDataIn(upperDataIn),
        .upperDataOut(upperDataOut), .upperDataEnN(upperDataEnN));

    always #4 ref_clk = ~ref_clk;

    task automatic complete_run();
        if (n_fail == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        // besides pready, only the bench timeout ends this wait
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rreg(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
    endtask
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic status();
        logic [31:0] r;
        rreg(`NIP_OFS_STATUS, r);
        st = nip_status_s'(r[11:0]);
    endtask
    task automatic step_is(input nip_step_e e);
        status();
        chk({28'h0, st.step}, {28'h0, e});
    endtask

    task automatic check_reset();
        rreg(`NIP_OFS_CTRL, rd);
        chk(rd, 32'h0000_0001);
        step_is(ST_POR);
        chk({30'h0, st.busy, st.fourBit}, 32'h2);
        chk({30'h0, st.initDone, st.incr}, 32'h1);
        apb(1'b0, 12'h010, 32'h0000_0000, rd, err);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0000_0000);
        apb(1'b1, 12'h010, 32'hFFFF_FFFF, rd, err);
        chk({31'h0, err}, 32'h1);
        chk({31'h0, upperDataEnN}, 32'h1);
    endtask

    task automatic check_early();
        nip_host_model_inst.wr_nib(4'h3);
        rreg(`NIP_OFS_ERR, rd);
        chk(rd, 32'h0000_0001);
        wreg(`NIP_OFS_ERR, 32'h0000_0003);
        rreg(`NIP_OFS_ERR, rd);
        chk(rd, 32'h0000_0000);
        wreg(`NIP_OFS_CTRL, 32'h0000_0003);
        step_is(ST_POR);
        rreg(`NIP_OFS_CTRL, rd);
        chk(rd, 32'h0000_0001);
    endtask

    task automatic check_init();
        nip_host_model_inst.wait_cyc(POR + 4);
        nip_host_model_inst.wr_nib(4'h3);
        nip_host_model_inst.rd_nib(nib, enN);
        chk({31'h0, enN}, 32'h0);
        chk({31'h0, nib[3]}, 32'h0);
        step_is(ST_FS1);
        nip_host_model_inst.wait_cyc(GAP1 + 4);
        nip_host_model_inst.wr_nib(4'h3);
        step_is(ST_FS2);
        nip_host_model_inst.wait_cyc(GAP2 + 4);
        nip_host_model_inst.wr_nib(4'h3);
        step_is(ST_FS3);
        nip_host_model_inst.wait_cyc(EXEC + 4);
        nip_host_model_inst.wr_nib(4'h2);
        // poll at once while the switch still executes
        nip_host_model_inst.rd_nib(nib, enN);
        chk({31'h0, nib[3]}, 32'h1);
        nip_host_model_inst.rd_nib(nib, enN);
        step_is(ST_WIDTH4);
        chk({31'h0, st.fourBit}, 32'h1);
        nip_host_model_inst.wait_cyc(EXEC + 4);
        nip_host_model_inst.rd_nib(nib, enN);
        chk({31'h0, nib[3]}, 32'h0);
        nip_host_model_inst.rd_nib(nib, enN);
        nip_host_model_inst.wr_pair(4'h2, 4'h8);
        step_is(ST_FS4);
        chk({30'h0, st.voltGen, st.lineCount}, 32'h1);
        nip_host_model_inst.wait_cyc(EXEC + 4);
        nip_host_model_inst.wr_pair(4'h0, 4'h8);
        step_is(ST_DOFF);
        chk({31'h0, st.dispOn}, 32'h0);
        nip_host_model_inst.wait_cyc(EXEC + 4);
        nip_host_model_inst.wr_pair(4'h0, 4'h1);
        step_is(ST_CLR);
        nip_host_model_inst.wait_cyc(CLR + 4);
        nip_host_model_inst.wr_pair(4'h0, 4'h5);
        step_is(ST_DONE);
        chk({29'h0, st.initDone, st.shift, st.incr}, 32'h6);
        rreg(`NIP_OFS_INSTR, rd);
        chk(rd, 32'h0000_0005);
        rreg(`NIP_OFS_ERR, rd);
        chk(rd, 32'h0000_0000);
        // a data write moves the address counter down, as entry mode chose decrement
        nip_host_model_inst.wait_cyc(EXEC + 4);
        nip_host_model_inst.rsSel = 1'b1;
        nip_host_model_inst.wr_pair(4'h4, 4'h1);
        nip_host_model_inst.rsSel = 1'b0;
        nip_host_model_inst.wait_cyc(EXEC + 4);
        nip_host_model_inst.rd_nib(nib, enN);
        chk({28'h0, nib}, 32'h7);
        nip_host_model_inst.rd_nib(nib, enN);
        chk({28'h0, nib}, 32'hF);
        nip_host_model_inst.rsSel = 1'b1;
        nip_host_model_inst.rd_nib(nib, enN);
        chk({28'h0, nib}, 32'h0);
        nip_host_model_inst.rsSel = 1'b0;
    endtask

    task automatic check_order();
        wreg(`NIP_OFS_CTRL, 32'h0000_0003);
        nip_host_model_inst.wait_cyc(POR + 4);
        nip_host_model_inst.wr_nib(4'h2);
        rreg(`NIP_OFS_ERR, rd);
        chk(rd, 32'h0000_0002);
        // a disabled port must not drive the lines back
        wreg(`NIP_OFS_CTRL, 32'h0000_0000);
        nip_host_model_inst.rd_nib(nib, enN);
        chk({31'h0, enN}, 32'h1);
        wreg(`NIP_OFS_CTRL, 32'h0000_0001);
    endtask

    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        check_reset();
        check_early();
        check_init();
        check_order();
        complete_run();
    end
endmodule
`default_nettype wire
